// >>> shared/npo_pkg.sv
// Package with offsets, field positions, resets and decode codes.
package npo_pkg;
	// Register word indexes; every APB byte offset below is the index times four.
	localparam logic [3:0] PT_IDX = 4'h8; // Passive target options index.
	localparam logic [3:0] SM_IDX = 4'h9; // Stream mode options index.
	localparam logic [3:0] AX_IDX = 4'hA; // Auxiliary options index.
	localparam logic [3:0] ST_IDX = 4'hB; // Derived status index.
	localparam logic [7:0] PT_ADDR = {2'h0, PT_IDX, 2'h0};
	localparam logic [7:0] SM_ADDR = {2'h0, SM_IDX, 2'h0};
	localparam logic [7:0] AX_ADDR = {2'h0, AX_IDX, 2'h0};
	localparam logic [7:0] ST_ADDR = {2'h0, ST_IDX, 2'h0};
	// Writable bit masks; reserved bits are dropped on write.
	localparam logic [7:0] PT_MASK = 8'hFD;
	localparam logic [7:0] SM_MASK = 8'h7F;
	localparam logic [7:0] AX_MASK = 8'hBF;
	localparam logic [7:0] REG_RST = 8'h00;
	// Field positions.
	localparam int FDEL_HI = 7;
	localparam int FDEL_LO = 4;
	localparam int P2P_OFF_BIT = 3;
	localparam int FELPOLL_OFF_BIT = 2;
	localparam int TYPEA_OFF_BIT = 0;
	localparam int SCF_HI = 6;
	localparam int SCF_LO = 5;
	localparam int SCP_HI = 4;
	localparam int SCP_LO = 3;
	localparam int STX_HI = 2;
	localparam int STX_LO = 0;
	localparam int SKIPCRC_BIT = 7;
	localparam int UID_HI = 5;
	localparam int UID_LO = 4;
	localparam int QSHIFT_BIT = 3;
	localparam int PULSE_BIT = 2;
	localparam int NVAL_HI = 1;
	localparam int NVAL_LO = 0;
	// Receive protocol selector codes.
	typedef enum logic [2:0] {
		NPO_RX_ISOA = 3'h0,
		NPO_RX_ISOB = 3'h1,
		NPO_RX_NFCF = 3'h3,
		NPO_RX_T1T = 3'h2,
		NPO_RX_STREAM = 3'h6
	} npo_rxproto_e;
	// Stream subcarrier division codes and log2 of dividers.
	localparam logic [1:0] SCF_F16 = 2'h2;
	localparam logic [1:0] SCF_F32 = 2'h1;
	localparam logic [1:0] SCP_P8 = 2'h3;
	localparam logic [3:0] LOG_DIV64 = 4'h6;
	localparam logic [3:0] LOG_DIV16 = 4'h4;
	localparam logic [3:0] LOG_DIV128 = 4'h7;
	localparam logic [3:0] LOG_INVALID = 4'h0;
endpackage

// >>> hdl/npo_stream_decode.sv
// Decoder of stream mode fields into divider and pulse figures.
`timescale 1ns/1ps
module npo_stream_decode (
	input wire logic bpskMode, // High when BPSK stream is selected.
	input wire logic [1:0] scfSel, // Subcarrier frequency code.
	input wire logic [1:0] scpSel, // Pulse count code.
	input wire logic [2:0] stxSel, // Tx modulator period code.
	output logic [3:0] subLog2Div, // log2 of carrier divider, 0 if invalid.
	output logic [3:0] pulseCount, // Pulses per report, 0 if invalid.
	output logic [3:0] txLog2Div, // log2 of Tx period divider, 0 if RFU.
	output logic cfgValid // High when every field is legal.
);
	import npo_pkg::*;

	// Subcarrier divider and pulse count follow the stream style.
	always_comb begin
		// (R8) subcarrier divider select
		if (bpskMode) begin
			subLog2Div = (scfSel == 2'h0) ? LOG_DIV16 : LOG_INVALID;
		end else begin
			subLog2Div = 4'(LOG_DIV64 - {2'h0, scfSel});
		end
		// (R9) pulse count select
		pulseCount = 4'(4'h1 << scpSel);
		if (!bpskMode && !scpSel[1]) begin
			pulseCount = 4'h0;
		end
	end

	// (R10) Tx period, top bit reserved.
	assign txLog2Div = stxSel[2] ? LOG_INVALID :
		4'(LOG_DIV128 - {2'h0, stxSel[1:0]});
	assign cfgValid = (subLog2Div != LOG_INVALID) &&
		(pulseCount != 4'h0) && (txLog2Div != LOG_INVALID);
endmodule

// >>> hdl/npo_rx_select.sv
// Receiver style and CRC bypass selection.
`timescale 1ns/1ps
module npo_rx_select (
	input wire logic [2:0] rxProto, // Receive protocol code.
	input wire logic [1:0] scfSel, // Stream subcarrier code.
	input wire logic [1:0] scpSel, // Stream pulse count code.
	input wire logic pulseSel, // Pulse receiver select bit.
	input wire logic skipCrcCfg, // Software CRC bypass bit.
	input wire logic autoNoCrc, // REQA/WUPA or anticollision running.
	output logic usePulse, // High for pulse reception.
	output logic rxStyleBad, // High when requested style is unavailable.
	output logic crcCheckEn // High when receive CRC is checked.
);
	import npo_pkg::*;
	logic corrAvail; // Correlator reception is possible.
	logic pulseAvail; // Pulse reception is possible.

	// (R16) correlator or pulse reception
	always_comb begin
		corrAvail = 1'b1;
		pulseAvail = 1'b1;
		case (rxProto)
			NPO_RX_ISOA, NPO_RX_T1T: begin
				pulseAvail = 1'b0;
			end
			NPO_RX_STREAM: begin
				corrAvail = (scfSel == SCF_F32) && (scpSel == SCP_P8);
			end
			default: begin
				corrAvail = 1'b1;
			end
		endcase
		usePulse = pulseSel && pulseAvail;
		rxStyleBad = pulseSel ? !pulseAvail : !corrAvail;
	end

	// (R11) (R12) CRC check unless bypassed.
	assign crcCheckEn = !skipCrcCfg && !autoNoCrc;
endmodule

// >>> hdl/npo_option_regs.sv
// APB register bank of NFC protocol options and their derived controls.
`timescale 1ns/1ps

// Notes on behaviour
// (R1) Trim shortens frame delay by carrier periods.
// (R2) Zero trim gives the nominal delay.
// (R3) Software should start with trim two.
// (R4) Bit three disables active peer frames.
// (R5) Bit two suppresses automatic poll reply.
// (R6) Bit zero disables automatic type A anticollision.
// (R7) Disabled auto replies route all through FIFO.
// (R8) Subcarrier code picks the stream carrier divider.
// (R9) Pulse code picks pulses per report.
// (R10) Tx period code picks modulator divider.
// (R11) Bit seven skips receive CRC check.
// (R12) REQA, WUPA, anticollision skip CRC automatically.
// (R13) UID size code picks four or seven.
// (R14) Quarter shift clock for phase and PM.
// (R15) Software keeps quarter shift zero for PM.
// (R16) Pulse select bit chooses receiver style.
// (R17) Software picks a style the mode supports.
// (R18) Two bit n value feeds field commands.
// (R19) Software writes n before field commands.
// (R20) All bits reset zero and are RW.
// (R21) Reserved bits read zero, writes ignored.
module npo_option_regs (
	input wire logic clk, // 100 MHz clock.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready, always high.
	output logic pslverr, // APB error for unmapped address.
	input wire logic [15:0] nominalFdt, // Nominal frame delay in fc periods.
	input wire logic bpskMode, // High for BPSK stream mode.
	input wire logic [2:0] rxProto, // Active receive protocol code.
	input wire logic autoNoCrc, // REQA/WUPA or anticollision in progress.
	input wire logic usePm, // High while PM demodulation is used.
	output logic [15:0] frameDelay, // Frame delay in fc periods.
	output logic activeP2pRecogEn, // Active peer frame recognition on.
	output logic autoPollReplyEn, // Automatic poll reply allowed.
	output logic autoTypeaCollEn, // Automatic type A anticollision on.
	output logic fifoOnlyTarget, // Target exchanges go through FIFO only.
	output logic [3:0] subLog2Div, // Stream subcarrier divider, log2.
	output logic [3:0] pulseCount, // Stream pulses per report.
	output logic [3:0] txLog2Div, // Stream Tx period divider, log2.
	output logic crcCheckEn, // Receive CRC check enabled.
	output logic uidSeven, // High for 7 byte UID.
	output logic phaseClkShift, // 90 degree clock for phase measurement.
	output logic pmClkShift, // 90 degree clock for PM demodulation.
	output logic usePulse, // Pulse receiver in use.
	output logic [1:0] fieldOnN // The n value for field-on commands.
);
	import npo_pkg::*;

	logic [7:0] ptReg_ff; // Passive target options.
	logic [7:0] smReg_ff; // Stream mode options.
	logic [7:0] axReg_ff; // Auxiliary options.
	logic [31:0] prdata_ff; // Registered read data.
	logic pslverr_ff; // Registered error flag.
	logic [31:0] nxt_prdata; // Next read data.
	logic nxt_pslverr; // Next error flag.
	logic wrEn; // Write taken this cycle.
	logic rdEn; // Setup phase of a read.
	logic addrHit; // Address maps to a register.
	logic streamOk; // Stream fields legal.
	logic rxStyleBad; // Chosen receiver style unavailable.
	logic [4:0] fdelTrim; // Trim as an unsigned width-safe value.

	// The slave answers in one access cycle, so ready stays high.
	assign pready = 1'b1;
	assign wrEn = psel && penable && pwrite && addrHit;
	assign rdEn = psel && !penable && !pwrite;
	assign addrHit = (paddr == PT_ADDR) || (paddr == SM_ADDR) ||
		(paddr == AX_ADDR) || (paddr == ST_ADDR);

	// Passive target register write.
	always_ff @(posedge clk or negedge resetn) begin
		// (R20) reset to zero
		if (!resetn) begin
			ptReg_ff <= REG_RST;
		end else if (wrEn && paddr == PT_ADDR) begin
			// (R21) mask reserved bits
			ptReg_ff <= pwdata[7:0] & PT_MASK;
		end
	end

	// Stream mode register write.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			smReg_ff <= REG_RST;
		end else if (wrEn && paddr == SM_ADDR) begin
			// (R21) mask reserved bit
			smReg_ff <= pwdata[7:0] & SM_MASK;
		end
	end

	// Auxiliary register write.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			axReg_ff <= REG_RST;
		end else if (wrEn && paddr == AX_ADDR) begin
			// (R20) host writable bits
			axReg_ff <= pwdata[7:0] & AX_MASK;
		end
	end

	// Read mux, captured in setup so data is stable in access.
	always_comb begin
		nxt_prdata = prdata_ff;
		nxt_pslverr = 1'b0;
		if (rdEn) begin
			case (paddr)
				PT_ADDR: begin
					nxt_prdata = {24'h0, ptReg_ff};
				end
				SM_ADDR: begin
					nxt_prdata = {24'h0, smReg_ff};
				end
				AX_ADDR: begin
					nxt_prdata = {24'h0, axReg_ff};
				end
				ST_ADDR: begin
					// Status: stream legality, style fault, CRC check.
					nxt_prdata = {29'h0, crcCheckEn, rxStyleBad, streamOk};
				end
				default: begin
					nxt_prdata = 32'h0;
					nxt_pslverr = 1'b1;
				end
			endcase
		end else if (psel && !penable) begin
			nxt_pslverr = !addrHit;
		end else if (psel && penable) begin
			nxt_pslverr = pslverr_ff;
		end
	end

	// Registered read data and error.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata_ff <= 32'h0;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff && psel && penable;

	// (R1) (R2) trim subtracts carrier periods, zero keeps nominal.
	assign fdelTrim = {1'b0, ptReg_ff[FDEL_HI:FDEL_LO]};
	assign frameDelay = (nominalFdt > {11'h0, fdelTrim}) ?
		16'(nominalFdt - {11'h0, fdelTrim}) : 16'h0;

	// (R4) (R5) (R6) auto response switches, active when bit is zero.
	assign activeP2pRecogEn = !ptReg_ff[P2P_OFF_BIT];
	assign autoPollReplyEn = !ptReg_ff[FELPOLL_OFF_BIT];
	assign autoTypeaCollEn = !ptReg_ff[TYPEA_OFF_BIT];
	// (R7) host handles exchanges when automatic replies are off.
	assign fifoOnlyTarget = ptReg_ff[FELPOLL_OFF_BIT] &&
		ptReg_ff[TYPEA_OFF_BIT];

	// (R13) UID size, reserved codes treated as 4 bytes.
	assign uidSeven = (axReg_ff[UID_HI:UID_LO] == 2'h1);
	// (R14) quarter shift for phase and PM paths.
	assign phaseClkShift = axReg_ff[QSHIFT_BIT];
	assign pmClkShift = axReg_ff[QSHIFT_BIT] && usePm;
	// (R18) n value for field-on commands.
	assign fieldOnN = axReg_ff[NVAL_HI:NVAL_LO];

	// Stream field decode.
	npo_stream_decode uStream (
		.bpskMode(bpskMode),
		.scfSel(smReg_ff[SCF_HI:SCF_LO]),
		.scpSel(smReg_ff[SCP_HI:SCP_LO]),
		.stxSel(smReg_ff[STX_HI:STX_LO]),
		.subLog2Div(subLog2Div),
		.pulseCount(pulseCount),
		.txLog2Div(txLog2Div),
		.cfgValid(streamOk)
	);

	// Receiver style and CRC control.
	npo_rx_select uRx (
		.rxProto(rxProto),
		.scfSel(smReg_ff[SCF_HI:SCF_LO]),
		.scpSel(smReg_ff[SCP_HI:SCP_LO]),
		.pulseSel(axReg_ff[PULSE_BIT]),
		.skipCrcCfg(axReg_ff[SKIPCRC_BIT]),
		.autoNoCrc(autoNoCrc),
		.usePulse(usePulse),
		.rxStyleBad(rxStyleBad),
		.crcCheckEn(crcCheckEn)
	);
endmodule

// >>> bench/npo_option_regs_chk.sv
// Checker of the option register bank, watching its ports only.
`timescale 1ns/1ps
module npo_option_regs_chk (
	input wire logic clk, // Clock.
	input wire logic resetn, // Reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB direction.
	input wire logic [7:0] paddr, // APB address.
	input wire logic [31:0] pwdata, // APB write data.
	input wire logic [15:0] nominalFdt, // Nominal delay.
	input wire logic bpskMode, // BPSK stream.
	input wire logic autoNoCrc, // Automatic CRC skip.
	input wire logic usePm, // PM demodulation in use.
	input wire logic [15:0] frameDelay, // Delay out.
	input wire logic activeP2pRecogEn, // Peer frames on.
	input wire logic autoPollReplyEn, // Poll reply on.
	input wire logic autoTypeaCollEn, // Anticollision on.
	input wire logic fifoOnlyTarget, // FIFO only.
	input wire logic [3:0] subLog2Div, // Subcarrier divider.
	input wire logic [3:0] txLog2Div, // Tx divider.
	input wire logic crcCheckEn, // CRC check on.
	input wire logic phaseClkShift, // Phase clock shift.
	input wire logic pmClkShift, // PM clock shift.
	input wire logic [1:0] fieldOnN // Field-on n.
);
	import npo_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic acc; // Write access phase; the write lands at its edge.
	assign acc = psel && penable && pwrite;
	trim_delay_a: assert property (acc && paddr == PT_ADDR |=>
		frameDelay == (nominalFdt > $past(pwdata[7:4]) ?
		nominalFdt - $past(pwdata[7:4]) : 16'h0)) else $error("delay");
	p2p_enable_a: assert property (acc && paddr == PT_ADDR |=>
		activeP2pRecogEn == !$past(pwdata[3])) else $error("p2p");
	auto_reply_a: assert property (acc && paddr == PT_ADDR |=>
		{autoPollReplyEn, autoTypeaCollEn} == ~{$past(pwdata[2]),
		$past(pwdata[0])}) else $error("auto reply");
	fifo_only_a: assert property (fifoOnlyTarget ==
		(!autoPollReplyEn && !autoTypeaCollEn)) else $error("fifo");
	sub_freq_a: assert property (acc && paddr == SM_ADDR |=>
		subLog2Div == (bpskMode ? ($past(pwdata[6:5]) == 2'h0 ? 4'h4
		: 4'h0) : 4'h6 - $past(pwdata[6:5]))) else $error("subcarrier");
	tx_period_a: assert property (acc && paddr == SM_ADDR |=>
		txLog2Div == ($past(pwdata[2]) ? 4'h0 : 4'h7 - $past(pwdata[1:0])))
		else $error("tx period");
	crc_skip_a: assert property (acc && paddr == AX_ADDR |=>
		crcCheckEn == !($past(pwdata[7]) || autoNoCrc)) else $error("crc");
	crc_auto_a: assert property (autoNoCrc |-> !crcCheckEn)
		else $error("auto crc");
	pm_shift_a: assert property (pmClkShift ==
		(phaseClkShift && usePm)) else $error("pm shift");
	field_n_a: assert property (acc && paddr == AX_ADDR |=>
		fieldOnN == $past(pwdata[1:0])) else $error("field n");
endmodule
bind npo_option_regs npo_option_regs_chk npo_option_regs_chk_inst (.clk,
	.resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .nominalFdt,
	.bpskMode, .autoNoCrc, .usePm, .frameDelay, .activeP2pRecogEn,
	.autoPollReplyEn, .autoTypeaCollEn, .fifoOnlyTarget, .subLog2Div,
	.txLog2Div, .crcCheckEn, .phaseClkShift, .pmClkShift, .fieldOnN);

// >>> bench/tb_top.sv
// Self-checking testbench of the option register bank.
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module tb_top;
	import npo_pkg::*;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, lastErr;
	logic bpskMode, autoNoCrc, usePm, activeP2pRecogEn, autoPollReplyEn;
	logic autoTypeaCollEn, fifoOnlyTarget, crcCheckEn, uidSeven, usePulse;
	logic phaseClkShift, pmClkShift;
	logic [1:0] fieldOnN;
	logic [2:0] rxProto;
	logic [3:0] subLog2Div, pulseCount, txLog2Div;
	logic [7:0] paddr;
	logic [15:0] nominalFdt, frameDelay;
	logic [31:0] pwdata, prdata, r;
	logic [7:0] regs [3] = '{PT_ADDR, SM_ADDR, AX_ADDR}; // Mapped places.
	logic [7:0] masks [3] = '{PT_MASK, SM_MASK, AX_MASK}; // Writable bits.
	int nFail = 0;
	int numChecks = 0;
	npo_option_regs npo_option_regs_inst (.clk, .resetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .nominalFdt,
		.bpskMode, .rxProto, .autoNoCrc, .usePm, .frameDelay,
		.activeP2pRecogEn, .autoPollReplyEn, .autoTypeaCollEn,
		.fifoOnlyTarget, .subLog2Div, .pulseCount, .txLog2Div, .crcCheckEn,
		.uidSeven, .phaseClkShift, .pmClkShift, .usePulse, .fieldOnN);
	// Clock of 100 MHz.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Compares one value and counts it.
	task automatic check(input string n, input logic [31:0] e, g);
		numChecks++;
		if (g !== e) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	// One APB transfer, entered just after a rising edge.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, r);
	endtask
	task automatic rdc(input string n, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0, r);
		`CHK(n, e, r);
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Cuts a hang short; the tests need about 150 cycles.
	initial begin
		repeat (5000) @(posedge clk);
		nFail++;
		giveVerdict();
	end
	// Main sequence of tests.
	initial begin
		{psel, penable, pwrite, paddr, pwdata, resetn} = '0;
		{bpskMode, autoNoCrc, usePm, rxProto} = '0;
		nominalFdt = 16'h0100;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 3; i++) begin
			rdc("reset value", regs[i], 0);
			wr(regs[i], 32'hFFFF_FFFF);
			rdc("reserved bits", regs[i], masks[i]);
			wr(regs[i], 32'h0);
		end
		$display("test access done");
		`CHK("nominal", 16'h0100, frameDelay);
		wr(PT_ADDR, 32'h2D);
		`CHK("trim two", 16'h00FE, frameDelay);
		`CHK("fifo only", 1, fifoOnlyTarget);
		wr(PT_ADDR, 32'h04);
		`CHK("enables", 3'b101, {activeP2pRecogEn, autoPollReplyEn,
			autoTypeaCollEn});
		nominalFdt <= 16'h0003;
		wr(PT_ADDR, 32'hF0);
		`CHK("floor", 0, frameDelay);
		$display("test passive target done");
		for (int b = 0; b < 2; b++) begin
			for (int c = 0; c < 8; c++) begin
				bpskMode <= b[0];
				wr(SM_ADDR, 32'({c[1:0], c[1:0], c[2:0]}));
				`CHK("sub", b ? (c[1:0] == 0 ? 4 : 0) : 6 - c[1:0],
					subLog2Div);
				`CHK("pulses", (b || c[1]) ? 1 << c[1:0] : 0,
					pulseCount);
				`CHK("tx", c[2] ? 0 : 7 - c, txLog2Div);
			end
		end
		$display("test stream done");
		for (int c = 0; c < 4; c++) begin
			wr(AX_ADDR, 32'(c));
			`CHK("field n", c, fieldOnN);
		end
		usePm <= 1'b1;
		wr(AX_ADDR, 32'h9C);
		`CHK("crc", 0, crcCheckEn);
		`CHK("uid", 1, uidSeven);
		`CHK("shift", 2'b11, {phaseClkShift, pmClkShift});
		`CHK("pulse isoa", 0, usePulse);
		rdc("style isoa", ST_ADDR, 32'h2);
		rxProto <= NPO_RX_ISOB;
		@(posedge clk);
		`CHK("pulse isob", 1, usePulse);
		wr(AX_ADDR, 32'h20);
		`CHK("uid rfu", 0, uidSeven);
		`CHK("pm noshift", 0, pmClkShift);
		autoNoCrc <= 1'b1;
		@(posedge clk);
		`CHK("auto crc", 0, crcCheckEn);
		autoNoCrc <= 1'b0;
		$display("test auxiliary done");
		wr(8'h40, 32'hFF);
		`CHK("unmapped err", 1, lastErr);
		rdc("unmapped data", 8'h40, 0);
		wr(PT_ADDR, 32'hFF);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rdc("second reset", PT_ADDR, 0);
		$display("test unmapped and reset done");
		giveVerdict();
	end
endmodule
